// File: gpb_board_model.sv
// Board model for the port B pins: device drive, board drive, pull-ups.
// Assumes pins are sampled on clk_sys; a pin nobody drives and with no
// pull-up shows a changing pattern, never a steady level.
module gpb_board_model (
    input  wire logic        clk_sys,
    input  wire logic [7:0]  pin_out,
    input  wire logic [7:0]  pin_oe,
    input  wire logic [7:0]  pin_pu,
    input  wire logic [7:0]  ext_en,
    input  wire logic [7:0]  ext_val,
    output logic      [7:0]  pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] float_q = 8'h55;

    always @(posedge clk_sys) begin
        float_q <= ~float_q;
    end

    // Device drive wins, then the board, then the weak pull-up
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i]
                      : pin_pu[i] ? 1'b1 : float_q[i];
        end
    end
endmodule : gpb_board_model

// File: gpb_pad_drv.sv
// Registered per-pin drivers for port B: output, enable and weak pull-up.
// Assumes the core supplies latch, direction and programming-mode controls.
module gpb_pad_drv (
    input  wire logic  clk_sys,
    input  wire logic  srst,
    gpb_pad_if.pad     pad
);

    // ------------------------------------------------------------------
    // Per-pin drive logic
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 8; i++) begin : g_pin
        logic prog_in;
        logic dat_d;
        logic oe_d;
        logic out_q;
        logic oe_q;
        logic pu_q;

        // Pin 6 is a clock input and pin 7 follows the programmer
        assign prog_in = pad.prog_mode &&
                         (i == gpb_pkg::PROG_CLK_PIN ||
                          i == gpb_pkg::PROG_DAT_PIN);
        assign dat_d = (prog_in && i == gpb_pkg::PROG_DAT_PIN) ?
                       pad.prog_dout : pad.latch[i];
        assign oe_d = prog_in ?
                      (i == gpb_pkg::PROG_DAT_PIN && pad.prog_doe) :
                      !pad.dir[i];

        always_ff @(posedge clk_sys) begin
            if (srst) begin
                out_q <= 1'b0;
                oe_q  <= 1'b0;
                pu_q  <= 1'b0;
            end else begin
                out_q <= dat_d;
                oe_q  <= oe_d;
                pu_q  <= !pad.pullup_disable_n && pad.dir[i];
            end
        end

        assign pad.pin_out[i] = out_q;
        assign pad.pin_oe[i]  = oe_q;
        assign pad.pin_pu[i]  = pu_q;
    end

endmodule : gpb_pad_drv

// File: gpb_pad_if.sv
// Carrier between the port B register core and its pad driver.
// Assumes both ends share clk_sys.
interface gpb_pad_if;
    logic [7:0] latch;
    logic [7:0] dir;
    logic       pullup_disable_n;
    logic       prog_mode;
    logic       prog_dout;
    logic       prog_doe;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
    logic [7:0] pin_pu;

    modport core (
        output latch, dir, pullup_disable_n, prog_mode, prog_dout, prog_doe,
        input  pin_out, pin_oe, pin_pu
    );
    modport pad (
        input  latch, dir, pullup_disable_n, prog_mode, prog_dout, prog_doe,
        output pin_out, pin_oe, pin_pu
    );
endinterface : gpb_pad_if

// File: gpb_pkg.sv
// Constants shared by the port B block: register indices, fields, resets.
// Assumes an APB master with 32-bit data; byte address = 4 * index.
package gpb_pkg;

    // ------------------------------------------------------------------
    // Register indices and address width
    // ------------------------------------------------------------------
    localparam int unsigned    ADDR_W        = 12;
    localparam logic [9:0]     IDX_DATA      = 10'h006;
    localparam logic [9:0]     IDX_OPTION    = 10'h081;
    localparam logic [9:0]     IDX_DIR       = 10'h086;
    localparam logic [9:0]     IDX_INTCTL    = 10'h08b;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned    OPT_PU_DIS_N  = 7;
    localparam int unsigned    OPT_EDGE_SEL  = 6;
    localparam int unsigned    IC_EXT_EN     = 4;
    localparam int unsigned    IC_CHG_EN     = 3;
    localparam int unsigned    IC_EXT_FLAG   = 1;
    localparam int unsigned    IC_CHG_FLAG   = 0;
    localparam int unsigned    EXT_PIN       = 0;
    localparam int unsigned    PROG_CLK_PIN  = 6;
    localparam int unsigned    PROG_DAT_PIN  = 7;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]     RST_OPTION    = 8'hff;
    localparam logic [7:0]     RST_DIR       = 8'hff;
    localparam logic [7:0]     RST_INTCTL    = 8'h00;

endpackage : gpb_pkg

// File: gpb_port.sv
// Eight-bit port B with direction, pull-ups, pin 0 interrupt, pin 4-7
// change detection and serial programming pins; APB register access.
// Assumes pins are synchronous to clk_sys and an external pad resolves
// pin_out/pin_oe/pin_pu into the board wire.
//
// Operation
// - The direction register resets to all ones, every pin an input.
// - The data latch is not reset and keeps its value through resets.
// - Pin 0 is both a general pin and the external interrupt input.
// - A level change on pins 4 to 7 is detected for an interrupt, only while the pin is an input.
// - Each pin has a weak pull-up, on only while the pin is an input and option bit 7 is clear.
// - In programming mode pin 6 is the clock input, pin 7 the data line.
module gpb_port (
    input  wire logic                        clk_sys,
    input  wire logic                        srst,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [gpb_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic [31:0]                      prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic [7:0]                  pin_in,
    output logic [7:0]                       pin_out,
    output logic [7:0]                       pin_oe,
    output logic [7:0]                       pin_pu,
    input  wire logic                        prog_mode,
    input  wire logic                        prog_dout,
    input  wire logic                        prog_doe,
    output logic                             prog_clock,
    output logic                             prog_data_in,
    output logic                             irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        GPB_IDLE = 2'b01,
        GPB_RESP = 2'b10
    } gpb_bus_t;

    gpb_bus_t     bus_q;
    gpb_bus_t     bus_d;
    logic [7:0]   latch_q;
    logic [7:0]   dir_q;
    logic [7:0]   opt_q;
    logic [7:0]   ictl_q;
    logic [7:0]   ictl_d;
    logic [7:0]   pin_q;
    logic [31:0]  prdata_q;
    logic         pready_q;
    logic         pslverr_q;
    logic         prog_clk_q;
    logic         prog_dat_q;
    logic         irq_q;

    gpb_pad_if    pad_if ();

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    wire          setup    = psel && !penable && bus_q == GPB_IDLE;
    wire          acc      = psel && penable && pready_q;
    wire          wr_acc   = acc && pwrite && !pslverr_q;
    wire          aligned  = paddr[1:0] == 2'b00;
    wire [9:0]    idx      = paddr[gpb_pkg::ADDR_W-1:2];
    wire          hit_data = aligned && idx == gpb_pkg::IDX_DATA;
    wire          hit_opt  = aligned && idx == gpb_pkg::IDX_OPTION;
    wire          hit_dir  = aligned && idx == gpb_pkg::IDX_DIR;
    wire          hit_ictl = aligned && idx == gpb_pkg::IDX_INTCTL;
    wire          hit_any  = hit_data || hit_opt || hit_dir || hit_ictl;
    wire [7:0]    rd_byte  = hit_data ? pin_in :
                             hit_opt  ? opt_q  :
                             hit_dir  ? dir_q  :
                             hit_ictl ? ictl_q : 8'h00;

    // ------------------------------------------------------------------
    // Pin events
    // ------------------------------------------------------------------
    wire          ext_rise = pin_in[gpb_pkg::EXT_PIN] &&
                             !pin_q[gpb_pkg::EXT_PIN];
    wire          ext_fall = !pin_in[gpb_pkg::EXT_PIN] &&
                             pin_q[gpb_pkg::EXT_PIN];
    wire          ext_evt  = opt_q[gpb_pkg::OPT_EDGE_SEL] ?
                             ext_rise : ext_fall;
    wire [3:0]    chg_bits = (pin_in[7:4] ^ pin_q[7:4]) & dir_q[7:4];
    wire          chg_evt  = |chg_bits;
    wire          irq_d    = (ictl_q[gpb_pkg::IC_CHG_FLAG] &&
                              ictl_q[gpb_pkg::IC_CHG_EN]) ||
                             (ictl_q[gpb_pkg::IC_EXT_FLAG] &&
                              ictl_q[gpb_pkg::IC_EXT_EN]);

    // ------------------------------------------------------------------
    // Interrupt control next value: a hardware set beats a clear
    // ------------------------------------------------------------------
    always_comb begin
        ictl_d = ictl_q;
        if (wr_acc && hit_ictl) begin
            ictl_d = pwdata[7:0];
        end
        if (ext_evt) begin
            ictl_d[gpb_pkg::IC_EXT_FLAG] = 1'b1;
        end
        if (chg_evt) begin
            ictl_d[gpb_pkg::IC_CHG_FLAG] = 1'b1;
        end
    end

    always_comb begin
        bus_d = bus_q;
        case (bus_q)
            GPB_IDLE: begin
                if (setup) begin
                    bus_d = GPB_RESP;
                end
            end
            GPB_RESP: begin
                bus_d = GPB_IDLE;
            end
            default: begin
                bus_d = GPB_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // APB slave: answers in the first access cycle
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            bus_q     <= GPB_IDLE;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            bus_q     <= bus_d;
            pready_q  <= setup;
            pslverr_q <= setup && !hit_any;
            if (setup && !pwrite) begin
                prdata_q <= {24'h00_0000, rd_byte};
            end else if (!setup) begin
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Data latch: no reset, held through every reset
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (wr_acc && hit_data && !srst) begin
            latch_q <= pwdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // Configuration and flag registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            dir_q  <= gpb_pkg::RST_DIR;
            opt_q  <= gpb_pkg::RST_OPTION;
            ictl_q <= gpb_pkg::RST_INTCTL;
        end else begin
            ictl_q <= ictl_d;
            if (wr_acc && hit_dir) begin
                dir_q <= pwdata[7:0];
            end
            if (wr_acc && hit_opt) begin
                opt_q <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Pin sampling, programming taps and interrupt output
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pin_q      <= pin_in;
            prog_clk_q <= 1'b0;
            prog_dat_q <= 1'b0;
            irq_q      <= 1'b0;
        end else begin
            pin_q      <= pin_in;
            prog_clk_q <= prog_mode && pin_in[gpb_pkg::PROG_CLK_PIN];
            prog_dat_q <= prog_mode && pin_in[gpb_pkg::PROG_DAT_PIN];
            irq_q      <= irq_d;
        end
    end

    // ------------------------------------------------------------------
    // Pad driver
    // ------------------------------------------------------------------
    assign pad_if.latch            = latch_q;
    assign pad_if.dir              = dir_q;
    assign pad_if.pullup_disable_n = opt_q[gpb_pkg::OPT_PU_DIS_N];
    assign pad_if.prog_mode        = prog_mode;
    assign pad_if.prog_dout        = prog_dout;
    assign pad_if.prog_doe         = prog_doe;

    gpb_pad_drv u_pad (
        .clk_sys (clk_sys),
        .srst    (srst),
        .pad     (pad_if.pad)
    );

    assign pin_out      = pad_if.pin_out;
    assign pin_oe       = pad_if.pin_oe;
    assign pin_pu       = pad_if.pin_pu;
    assign prdata       = prdata_q;
    assign pready       = pready_q;
    assign pslverr      = pslverr_q;
    assign prog_clock   = prog_clk_q;
    assign prog_data_in = prog_dat_q;
    assign irq          = irq_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);

    a_dir_reset_ones: assert property (
        @(posedge clk_sys) disable iff (1'b0)
        srst |=> dir_q == gpb_pkg::RST_DIR)
        else $error("direction not all inputs after reset");

    a_latch_kept_reset: assert property (
        @(posedge clk_sys) disable iff (1'b0)
        srst && !$past(srst) |=> latch_q == $past(latch_q))
        else $error("data latch changed during reset");

    a_data_read_pins: assert property (
        setup && !pwrite && hit_data |=>
        prdata[7:0] == $past(pin_in) && pready ##1 !pready)
        else $error("data read did not return pin levels");

    a_data_write_latch: assert property (
        wr_acc && hit_data |=> latch_q == $past(pwdata[7:0]))
        else $error("data write did not load latch");

    a_ext_edge_flag: assert property (
        ext_evt |=> ictl_q[gpb_pkg::IC_EXT_FLAG])
        else $error("pin 0 edge did not set its flag");

    a_change_flag_set: assert property (
        (|((pin_in[7:4] ^ pin_q[7:4]) & dir_q[7:4])) |=>
        ictl_q[gpb_pkg::IC_CHG_FLAG])
        else $error("change on pins 4-7 did not set flag");

    a_pullup_follow: assert property (
        !$rose(srst) |=> pin_pu ==
        ($past(dir_q) & {8{!$past(opt_q[gpb_pkg::OPT_PU_DIS_N])}}))
        else $error("pull-up does not follow control");

    a_prog_clk_input: assert property (
        prog_mode |=> !pin_oe[gpb_pkg::PROG_CLK_PIN])
        else $error("programming clock pin driven");

    a_irq_gated: assert property (
        !ictl_q[gpb_pkg::IC_CHG_EN] && !ictl_q[gpb_pkg::IC_EXT_EN]
        ##1 !ictl_q[gpb_pkg::IC_CHG_EN] && !ictl_q[gpb_pkg::IC_EXT_EN]
        |-> !irq)
        else $error("interrupt raised while disabled");

    a_bad_addr_err: assert property (
        setup && !hit_any |=>
        pready && pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    a_ready_one_cycle: assert property (
        pready |=> !pready)
        else $error("ready held for more than one cycle");

    a_irq_follow: assert property (
        ictl_q[gpb_pkg::IC_CHG_FLAG] && ictl_q[gpb_pkg::IC_CHG_EN]
        |=> irq)
        else $error("enabled change flag did not raise interrupt");

    a_prog_data_drive: assert property (
        prog_mode && prog_doe |=> pin_oe[gpb_pkg::PROG_DAT_PIN] &&
        pin_out[gpb_pkg::PROG_DAT_PIN] == $past(prog_dout))
        else $error("programming data pin not driven");

    a_dir_sets_oe: assert property (
        !prog_mode |=> pin_oe == ~$past(dir_q))
        else $error("pin enables do not follow direction");

    c_change_irq: cover property (
        chg_evt && ictl_q[gpb_pkg::IC_CHG_EN] ##2 irq);
    c_ext_irq: cover property (ext_evt ##1 ictl_q[gpb_pkg::IC_EXT_FLAG]);
    c_prog_drive: cover property (prog_mode && prog_doe ##1 pin_oe[7]);
    c_bad_addr: cover property (pslverr);
    c_fall_edge: cover property (ext_evt && !opt_q[gpb_pkg::OPT_EDGE_SEL]);

endmodule : gpb_port

// File: gpb_port_tb_top.sv
// Testbench for port B: registers over APB, pins, change and pin 0 irq.
// Assumes the board model resolves the pins and clk_sys runs at 200 MHz.
module gpb_port_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------------------------------
    // Signals and design
    // ----------------------------------------------------------------
    localparam logic [11:0] A_DATA = {gpb_pkg::IDX_DATA, 2'b00};
    localparam logic [11:0] A_OPT  = {gpb_pkg::IDX_OPTION, 2'b00};
    localparam logic [11:0] A_DIR  = {gpb_pkg::IDX_DIR, 2'b00};
    localparam logic [11:0] A_IC   = {gpb_pkg::IDX_INTCTL, 2'b00};
    logic        clk_sys = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, irq, prog_clock, prog_data_in;
    logic [7:0]  pin_in, pin_out, pin_oe, pin_pu;
    logic        prog_mode = 1'b0;
    logic        prog_dout = 1'b0;
    logic        prog_doe = 1'b0;
    logic [7:0]  ext_en = 8'hff;
    logic [7:0]  ext_val = 8'h00;
    logic [31:0] lfsr_q = 32'h2a4f5480;
    logic [7:0]  m_lat, m_ic, m_fl;
    logic        m_en, v;
    int          err_total = 0;
    int          n_compared = 0;

    always #2.5 clk_sys = ~clk_sys;

    gpb_port gpb_port_inst (.clk_sys(clk_sys), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_pu(pin_pu), .prog_mode(prog_mode), .prog_dout(prog_dout),
        .prog_doe(prog_doe), .prog_clock(prog_clock),
        .prog_data_in(prog_data_in), .irq(irq));

    gpb_board_model gpb_board_model_inst (.clk_sys(clk_sys),
        .pin_out(pin_out), .pin_oe(pin_oe), .pin_pu(pin_pu),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr_next

    task automatic wrap_up;
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_rd

    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: pins %h expected %h", $time, got, exp);
        end
    endtask : chk_pin

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] rd,
                       output logic er);
        int n;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            $display("unexpected at %0t: pready %h expected %h", $time, 0, 1);
            wrap_up();
        end else begin
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h0, d}, r, e);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp,
                          input logic exp_err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk_rd(r, {24'h0, exp});
        chk_rd({31'h0, e}, {31'h0, exp_err});
    endtask : rd_chk

    task automatic reset_regs;
        rd_chk(A_DIR, 8'hff, 1'b0);
        rd_chk(A_OPT, 8'hff, 1'b0);
        rd_chk(A_IC, 8'h00, 1'b0);
        rd_chk(12'h000, 8'h00, 1'b1);
        rd_chk(A_DATA | 12'h001, 8'h00, 1'b1);
    endtask : reset_regs

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        reset_regs();
        $display("test reset values done");
        for (int k = 0; k < 2; k++) begin
            m_lat = lfsr_q[7:0];
            lfsr_q = lfsr_next(lfsr_q);
            wr(A_DATA, m_lat);
            wr(A_DIR, 8'h00);
            repeat (3) @(posedge clk_sys);
            chk_pin(pin_out, m_lat);
            chk_pin(pin_oe, 8'hff);
            rd_chk(A_DATA, m_lat, 1'b0);
            wr(A_DIR, 8'hff);
            ext_val <= ~m_lat;
            repeat (3) @(posedge clk_sys);
            chk_pin(pin_oe, 8'h00);
            rd_chk(A_DATA, ~m_lat, 1'b0);
        end
        $display("test latch and pins done");
        @(posedge clk_sys);
        srst <= 1'b1;
        @(posedge clk_sys);
        srst <= 1'b0;
        reset_regs();
        wr(A_DIR, 8'h00);
        repeat (3) @(posedge clk_sys);
        chk_pin(pin_out, m_lat);
        rd_chk(A_DATA, m_lat, 1'b0);
        $display("test latch through reset done");
        wr(A_OPT, 8'h7f);
        wr(A_DIR, 8'h0f);
        repeat (3) @(posedge clk_sys);
        chk_pin(pin_pu, 8'h0f);
        chk_pin(pin_oe, 8'hf0);
        wr(A_OPT, 8'hff);
        repeat (3) @(posedge clk_sys);
        chk_pin(pin_pu, 8'h00);
        $display("test pull-ups done");
        wr(A_DIR, 8'hff);
        ext_val <= 8'h00;
        repeat (4) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            m_en = (i % 3) != 1;
            m_ic = m_en ? 8'h18 : 8'h00;
            m_fl = {6'h0, i == 0, i >= 4};
            wr(A_IC, m_ic);
            ext_val[i] <= 1'b1;
            repeat (4) @(posedge clk_sys);
            rd_chk(A_IC, m_ic | m_fl, 1'b0);
            chk_pin({7'h0, irq}, {7'h0, m_en & (|m_fl)});
        end
        wr(A_OPT, 8'hbf);
        wr(A_IC, 8'h10);
        ext_val[0] <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rd_chk(A_IC, 8'h12, 1'b0);
        chk_pin({7'h0, irq}, 8'h01);
        $display("test change and pin 0 interrupt done");
        v = lfsr_q[0];
        prog_mode <= 1'b1;
        prog_doe <= 1'b1;
        prog_dout <= 1'b1;
        ext_val[6] <= v;
        repeat (4) @(posedge clk_sys);
        chk_pin({7'h0, prog_clock}, {7'h0, v});
        chk_pin({4'h0, pin_oe[7:6], pin_out[7], prog_data_in}, 8'h0b);
        prog_doe <= 1'b0;
        ext_val[7] <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk_pin({6'h0, pin_oe[7], prog_data_in}, 8'h00);
        $display("test programming pins done");
        wrap_up();
    end
endmodule : gpb_port_tb_top
